// >>> rtl/txam_pkg.sv
// txam_pkg: register map, field layout and reset values of the tx count and am depth register slice.
// assumes an 8-bit register space reached over a 32-bit apb slave.
package txam_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] TXAM_IDX_CNT_HI = 8'h1D;
    localparam logic [7:0] TXAM_IDX_CNT_LO = 8'h1E;
    localparam logic [7:0] TXAM_IDX_RATE = 8'h1F;
    localparam logic [7:0] TXAM_IDX_ADC = 8'h20;
    localparam logic [7:0] TXAM_IDX_RSV_A = 8'h21;
    localparam logic [7:0] TXAM_IDX_RSV_B = 8'h22;
    localparam logic [7:0] TXAM_IDX_RSV_C = 8'h23;
    localparam logic [7:0] TXAM_IDX_DEPTH = 8'h24;
    localparam logic [7:0] TXAM_IDX_SEG = 8'h26;
    localparam int TXAM_ADDR_W = 12;
    localparam int TXAM_CNT_W = 13;
    localparam int TXAM_NBIT_W = 3;
    localparam int TXAM_NBIT_LSB = 0;
    localparam int TXAM_CNTLO_LSB = 3;
    localparam int TXAM_CNTLO_W = 5;
    localparam int TXAM_RATE_LSB = 4;
    localparam int TXAM_RATE_W = 4;
    localparam int TXAM_MOD_LSB = 1;
    localparam int TXAM_MOD_W = 6;
    localparam int TXAM_AMS_BIT = 7;
    localparam logic [7:0] TXAM_RST8 = 8'h00;
    localparam logic [31:0] TXAM_RST32 = 32'h00000000;
    localparam logic [TXAM_NBIT_W-1:0] TXAM_NBIT_NONE = 3'h0;

    typedef enum logic [1:0] {
        TXAM_SRC_TARGET,
        TXAM_SRC_SEGMENT
    } txam_src_e;

    // byte address of a register index
    function automatic logic [TXAM_ADDR_W-1:0] txam_addr(input logic [7:0] idx);
        txam_addr = {2'h0, idx, 2'h0};
    endfunction : txam_addr
endpackage : txam_pkg

// >>> rtl/txam_reg_if.sv
// txam_reg_if: carries a decoded register write/read strobe between the apb front and the register top.
// assumes one clock domain.
`timescale 1ns/1ps
interface txam_reg_if;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
    modport bus (output wr, output rd, output idx, output wdata);
    modport regs (input wr, input rd, input idx, input wdata);
endinterface : txam_reg_if

// >>> rtl/txam_apb.sv
// txam_apb: apb slave front; turns a setup/access pair into one write or read strobe.
// assumes psel/penable from a well behaved master; answers with pready in the access cycle.
`timescale 1ns/1ps
module txam_apb
    import txam_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TXAM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // decoded strobes
    txam_reg_if.bus rif
);
    logic busy_r;
    logic go;

    // a request is taken once, at the first enabled edge that sees psel; normally the
    // setup edge, but a setup missed while frozen is taken in the access cycle instead
    // of leaving the bus hung with pready low
    assign go = psel && !busy_r && clk_en;

    // busy while the answer stands, so the access edge does not take the request again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= go;
        end
    end

    assign rif.wr = go && pwrite;
    assign rif.rd = go && !pwrite;
    assign rif.idx = paddr[9:2];
    assign rif.wdata = pwdata[7:0];
endmodule : txam_apb

// >>> rtl/txam_regs.sv
// txam_regs: tx byte count, split-byte bits, bit-rate and converter displays, am depth source select.
// assumes status inputs (rate, converter, calibration, wupa) are synchronous to pclk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module txam_regs
    import txam_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic set_default,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TXAM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmitter context
    input wire logic mode_type_a,
    input wire logic anticoll_en,
    input wire logic card_idle,
    input wire logic wupa_cmd,
    output logic [TXAM_CNT_W-1:0] tx_full_bytes,
    output logic [TXAM_NBIT_W-1:0] tx_split_bits,
    output logic tx_bit_frame,
    output logic tx_no_parity,
    output logic parity_irq,
    // displays
    input wire logic rate_valid,
    input wire logic [TXAM_RATE_W-1:0] rate_result,
    input wire logic adc_valid,
    input wire logic [7:0] adc_result,
    // modulation depth
    input wire logic cal_valid,
    input wire logic [TXAM_MOD_W-1:0] cal_target,
    input wire logic [7:0] seg_disable,
    output logic depth_source_select,
    output logic [7:0] am_level,
    output logic am_level_from_target
);
    txam_reg_if rif ();

    txam_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rif(rif)
    );

    logic [7:0] cnt_hi_r;
    logic [7:0] cnt_lo_r;
    logic [TXAM_RATE_W-1:0] rate_r;
    logic [7:0] adc_r;
    logic [7:0] depth_r;
    logic [7:0] rdata_nxt;
    logic hit;
    logic split;

    function automatic logic sel(input logic [7:0] idx, input logic [7:0] want);
        sel = (idx == want);
    endfunction : sel

    // address must be word aligned and within the printed window
    assign hit = (paddr[1:0] == 2'h0) && (paddr[TXAM_ADDR_W-1:10] == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_hi_r <= TXAM_RST8;
            cnt_lo_r <= TXAM_RST8;
        end else if (clk_en) begin
            if (set_default) begin
                cnt_hi_r <= TXAM_RST8;
                cnt_lo_r <= TXAM_RST8;
            end else if (rif.wr && hit) begin
                if (sel(rif.idx, TXAM_IDX_CNT_HI)) begin
                    cnt_hi_r <= rif.wdata;
                end
                if (sel(rif.idx, TXAM_IDX_CNT_LO)) begin
                    cnt_lo_r <= rif.wdata;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_r <= TXAM_RST8;
        end else if (clk_en) begin
            if (set_default) begin
                depth_r <= TXAM_RST8;
            end else if (cal_valid && !depth_r[TXAM_AMS_BIT]) begin
                // calibration updates target; it beats a simultaneous host write
                depth_r[TXAM_MOD_LSB +: TXAM_MOD_W] <= cal_target;
            end else if (rif.wr && hit && sel(rif.idx, TXAM_IDX_DEPTH)) begin
                depth_r <= {rif.wdata[7:1], 1'b0};
            end
        end
    end

    // displays cleared at reset and restore
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_r <= '0;
            adc_r <= TXAM_RST8;
        end else if (clk_en) begin
            if (set_default) begin
                rate_r <= '0;
                adc_r <= TXAM_RST8;
            end else begin
                if (rate_valid) begin
                    rate_r <= rate_result;
                end
                if (adc_valid) begin
                    adc_r <= adc_result;
                end
            end
        end
    end

    // read mux; reserved and unmapped read zero
    always_comb begin
        rdata_nxt = TXAM_RST8;
        if (hit) begin
            case (rif.idx)
                TXAM_IDX_CNT_HI: rdata_nxt = cnt_hi_r;
                TXAM_IDX_CNT_LO: rdata_nxt = cnt_lo_r;
                TXAM_IDX_RATE: rdata_nxt = {rate_r, 4'h0};
                TXAM_IDX_ADC: rdata_nxt = adc_r;
                TXAM_IDX_DEPTH: rdata_nxt = depth_r;
                default: rdata_nxt = TXAM_RST8;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= TXAM_RST32;
        end else if (rif.rd) begin
            prdata <= {24'h000000, rdata_nxt};
        end
    end

    // answer in the cycle after the request is taken, frozen or not; no request is taken
    // while frozen, so after the first frozen cycle pready stays low and the host just waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= rif.wr || rif.rd;
        end
    end

    // refused accesses complete quietly, so there is no error response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= 1'b0;
        end
    end

    // split bits; zero means all bytes complete
    assign split = cnt_lo_r[TXAM_NBIT_LSB +: TXAM_NBIT_W] != TXAM_NBIT_NONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full_bytes <= '0;
            tx_split_bits <= '0;
        end else if (clk_en) begin
            tx_full_bytes <= {cnt_hi_r, cnt_lo_r[TXAM_CNTLO_LSB +: TXAM_CNTLO_W]};
            tx_split_bits <= cnt_lo_r[TXAM_NBIT_LSB +: TXAM_NBIT_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_bit_frame <= 1'b0;
        end else if (clk_en) begin
            tx_bit_frame <= split && mode_type_a;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_no_parity <= 1'b0;
        end else if (clk_en) begin
            tx_no_parity <= split;
        end
    end

    // parity interrupt pulse, one cycle per wupa_cmd cycle with anticoll_en, card_idle and split bits; an outside interrupt register must catch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_irq <= 1'b0;
        end else if (clk_en) begin
            parity_irq <= wupa_cmd && anticoll_en && card_idle && split;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_source_select <= 1'b0;
            am_level_from_target <= 1'b0;
        end else if (clk_en) begin
            depth_source_select <= depth_r[TXAM_AMS_BIT];
            am_level_from_target <= !depth_r[TXAM_AMS_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            am_level <= TXAM_RST8;
        end else if (clk_en) begin
            // target field zero-extended; segment bits taken as is
            am_level <= depth_r[TXAM_AMS_BIT] ? seg_disable
                                              : {2'h0, depth_r[TXAM_MOD_LSB +: TXAM_MOD_W]};
        end
    end
endmodule : txam_regs

// >>> verif/txam_host.sv
// txam_host: apb master model for the host side of txam_regs.
// assumes pready comes back; each wait is bounded and counted in tmo.
`timescale 1ns/1ps
module txam_host
    import txam_pkg::*;
(
    // clock and answer
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [TXAM_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata
);
    int tmo = 0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        // setup phase starts just after a rising edge
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready and read data are taken only at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : txam_host

// >>> verif/txam_props.sv
// txam_props: port assertions for txam_regs.
// assumes clk_en is low only while the context inputs hold still.
`timescale 1ns/1ps
module txam_props
    import txam_pkg::*;
(
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TXAM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // context
    input wire logic mode_type_a,
    input wire logic anticoll_en,
    input wire logic card_idle,
    input wire logic wupa_cmd,
    input wire logic cal_valid,
    input wire logic [TXAM_MOD_W-1:0] cal_target,
    input wire logic [7:0] seg_disable,
    // outputs
    input wire logic [TXAM_CNT_W-1:0] tx_full_bytes,
    input wire logic [TXAM_NBIT_W-1:0] tx_split_bits,
    input wire logic tx_bit_frame,
    input wire logic tx_no_parity,
    input wire logic parity_irq,
    input wire logic depth_source_select,
    input wire logic [7:0] am_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wr_lo; s_setup ##0 (pwrite && paddr == 12'h078); endsequence
    sequence s_wr_dep; s_setup ##0 (pwrite && paddr == 12'h090 && !pwdata[7] && !cal_valid); endsequence
    sequence s_rd_rsv; s_setup ##0 (!pwrite && paddr inside {12'h084, 12'h088, 12'h08C}); endsequence
    AST_RST_ZERO: assert property (!$past(presetn) |-> tx_full_bytes == 13'h0000 && am_level == 8'h00)
        else $error("outputs not zero after reset");
    AST_LO_WRITE: assert property (s_wr_lo |=> ##1 tx_split_bits == $past(pwdata[2:0], 2)
        && tx_full_bytes[4:0] == $past(pwdata[7:3], 2)) else $error("low count write not seen");
    AST_NO_PARITY: assert property (tx_no_parity == (tx_split_bits != 3'h0))
        else $error("parity suppression wrong");
    AST_BIT_FRAME: assert property (tx_bit_frame == (tx_split_bits != 3'h0 && $past(mode_type_a)))
        else $error("bit frame flag wrong");
    AST_PAR_IRQ: assert property (parity_irq == ($past(wupa_cmd && anticoll_en && card_idle) && tx_split_bits != 3'h0))
        else $error("parity interrupt wrong");
    AST_SEG_LEVEL: assert property (depth_source_select |-> am_level == $past(seg_disable))
        else $error("segment level not used");
    AST_TGT_LEVEL: assert property (s_wr_dep |=> ##1 am_level == {2'b00, $past(pwdata[6:1], 2)})
        else $error("target level not used");
    AST_CAL_LEVEL: assert property (cal_valid && !psel ##1 !psel ##1 !depth_source_select |-> am_level[5:0] == $past(cal_target, 2))
        else $error("calibration not applied");
    AST_RSV_RD: assert property (s_rd_rsv |=> pready && prdata == 32'h00000000)
        else $error("reserved read not zero");
endmodule : txam_props
bind txam_regs txam_props props_i (.*);

// >>> verif/testbench.sv
// testbench: drives txam_regs through the host model and judges ports and registers.
// assumes 40 MHz pclk; clk_en is dropped only in the freeze scenario.
`timescale 1ns/1ps
module testbench;
    import txam_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, set_default = 1'b0, mode_type_a = 1'b0;
    logic anticoll_en = 1'b0, card_idle = 1'b0, wupa_cmd = 1'b0, rate_valid = 1'b0, adc_valid = 1'b0;
    logic cal_valid = 1'b0, psel, penable, pwrite, pready, pslverr, tx_bit_frame, tx_no_parity, parity_irq;
    logic depth_source_select, am_level_from_target;
    logic [3:0] rate_result = 4'h0;
    logic [5:0] cal_target = 6'h00;
    logic [7:0] adc_result = 8'h00, seg_disable = 8'h00, am_level;
    logic [TXAM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [12:0] tx_full_bytes;
    logic [2:0] tx_split_bits;
    int miscompares = 0, cmp_count = 0;
    always #12.5 pclk = ~pclk;
    txam_regs dut (.*);
    txam_host host (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        host.xfer(1'b0, i, 32'h00000000, q);
        chk(q, e);
        chk(pslverr, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        host.xfer(1'b1, i, d, q);
    endtask : wr
    task automatic t_zero;
        for (logic [7:0] i = 8'h1D; i <= 8'h24; i++) rd(i, 32'h00000000);
    endtask : t_zero
    task automatic t_count;
        mode_type_a <= 1'b1;
        wr(8'h1D, 32'h000000FF);
        wr(8'h1E, 32'h000000FB);
        rd(8'h1E, 32'h000000FB);
        @(negedge pclk);
        chk({tx_full_bytes, tx_split_bits, tx_no_parity, tx_bit_frame}, {13'h1FFF, 3'h3, 2'b11});
        wr(8'h1E, 32'h00000008);
        rd(8'h1E, 32'h00000008);
        @(negedge pclk);
        chk({tx_full_bytes, tx_split_bits, tx_no_parity, tx_bit_frame}, {13'h1FE1, 5'h00});
    endtask : t_count
    task automatic t_irq;
        wr(8'h1E, 32'h00000001);
        anticoll_en <= 1'b1;
        card_idle <= 1'b1;
        wupa_cmd <= 1'b1;
        @(posedge pclk);
        wupa_cmd <= 1'b0;
        @(negedge pclk);
        chk(parity_irq, 32'h1);
        @(negedge pclk);
        chk(parity_irq, 32'h0);
        mode_type_a <= 1'b0;
        repeat (2) @(negedge pclk);
        chk({tx_no_parity, tx_bit_frame}, 32'h2);
    endtask : t_irq
    task automatic t_freeze;
        clk_en <= 1'b0;
        set_default <= 1'b1;
        fork
            wr(8'h1D, 32'h00000012);
            begin
                repeat (2) @(posedge pclk);
                set_default <= 1'b0;
                clk_en <= 1'b1;
            end
        join
        rd(8'h1D, 32'h00000012);
        rd(8'h1E, 32'h00000001);
        chk(tx_full_bytes, 32'h240);
    endtask : t_freeze
    task automatic t_disp;
        rate_result <= 4'hA;
        adc_result <= 8'h5C;
        rate_valid <= 1'b1;
        adc_valid <= 1'b1;
        @(posedge pclk);
        rate_valid <= 1'b0;
        adc_valid <= 1'b0;
        rd(8'h1F, 32'h000000A0);
        wr(8'h20, 32'h000000FF);
        rd(8'h20, 32'h0000005C);
        wr(8'h22, 32'h000000FF);
        rd(8'h22, 32'h00000000);
        rd(8'h30, 32'h00000000);
        set_default <= 1'b1;
        @(posedge pclk);
        set_default <= 1'b0;
        t_zero();
    endtask : t_disp
    task automatic t_depth;
        wr(8'h24, 32'h0000007F);
        rd(8'h24, 32'h0000007E);
        @(negedge pclk);
        chk({am_level_from_target, am_level}, 32'h13F);
        @(posedge pclk);
        cal_target <= 6'h15;
        cal_valid <= 1'b1;
        seg_disable <= 8'hA5;
        @(posedge pclk);
        cal_valid <= 1'b0;
        rd(8'h24, 32'h0000002A);
        chk(am_level, 32'h15);
        wr(8'h24, 32'h00000080);
        rd(8'h24, 32'h00000080);
        chk({depth_source_select, am_level}, 32'h1A5);
        set_default <= 1'b1;
        @(posedge pclk);
        set_default <= 1'b0;
        rd(8'h24, 32'h00000000);
        chk({depth_source_select, am_level}, 32'h0);
    endtask : t_depth
    task automatic wrap_up;
        miscompares += host.tmo;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_zero();
        t_count();
        t_irq();
        t_freeze();
        t_disp();
        t_depth();
        wrap_up();
    end
    // hang guard: a stuck run is a mismatch
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
endmodule : testbench
